/* File: core/dua_chan.sv */
// Purpose: One serial port: rate counter, transmitter and receiver.
// Assumes: rxd_i is already synchronised to clk_i.
// Notes: The divisor counts clock cycles per sixteenth of a bit.
`timescale 1ns/1ns
`include "dua_consts.svh"

module dua_chan import dua_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [15:0] div_i,
  input wire logic tx_load_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_ninth_i,
  input wire logic nine_bit_i,
  input wire logic par_auto_i,
  input wire logic par_odd_i,
  input wire logic two_stop_i,
  input wire logic flow_en_i,
  input wire logic rx_en_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_busy_o,
  output logic tx_done_o,
  output logic rx_done_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_o
);

  // ****************************************************************
  // Rate counter
  // ****************************************************************
  logic [15:0] cnt_r;
  wire tick_w = (cnt_r >= (div_i - 16'd1));

  // Compare with >= so a smaller divisor written mid-count recovers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_r <= 16'h0000;
    else if (ce_i) cnt_r <= tick_w ? 16'h0000 : cnt_r + 16'd1;
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [3:0] tx_ph_r;
  logic tx_pend_r;
  logic [7:0] tx_hold_r;
  logic tx_done_r;
  logic paused_r;

  // Frame packed LSB first; the spare top bits are stop-level ones.
  wire tx_idle_w = (tx_left_r == 4'h0);
  wire tx_start_w = tx_pend_r & tx_idle_w & ~paused_r & ~tx_load_i;
  wire ninth_w = par_auto_i ? (^tx_hold_r ^ par_odd_i) : tx_ninth_i;
  wire [11:0] frame_w = nine_bit_i ? {2'b11, ninth_w, tx_hold_r, 1'b0}
                                   : {3'b111, tx_hold_r, 1'b0};
  wire [3:0] frame_len_w = 4'd10 + {3'b000, nine_bit_i}
                                 + {3'b000, two_stop_i};
  wire tx_bit_end_w = tick_w & (tx_ph_r == `DUA_OVS_LAST) & ~tx_idle_w;

  // A write while busy is held and sent after the current frame.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_hold_r <= 8'h00;
      tx_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (tx_load_i) begin
        tx_hold_r <= tx_data_i;
        tx_pend_r <= 1'b1;
      end else if (tx_start_w) tx_pend_r <= 1'b0;
    end
  end

  // The shifter resets to ones, so its low bit is the idle-high line.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_r <= 12'hfff;
      tx_left_r <= 4'h0;
      tx_ph_r <= 4'h0;
      tx_done_r <= 1'b0;
    end else if (ce_i) begin
      tx_done_r <= tx_bit_end_w & (tx_left_r == 4'h1);
      if (tx_start_w) begin
        tx_sh_r <= frame_w;
        tx_left_r <= frame_len_w;
        tx_ph_r <= 4'h0;
      end else if (tick_w & ~tx_idle_w) begin
        tx_ph_r <= tx_ph_r + 4'h1;
        if (tx_bit_end_w) begin
          tx_sh_r <= {1'b1, tx_sh_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
        end
      end
    end
  end

  assign txd_o = tx_sh_r[0];
  assign tx_busy_o = tx_pend_r | ~tx_idle_w;
  assign tx_done_o = tx_done_r;

  // ****************************************************************
  // Receiver
  // ****************************************************************
  dua_rx_state_t rx_st_r;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_cnt_r;
  logic [9:0] rx_sh_r;
  logic [7:0] rx_data_r;
  logic rx_ninth_r;
  logic rx_done_r;

  wire [3:0] rx_len_w = nine_bit_i ? 4'd10 : 4'd9;
  wire [9:0] rx_sh_nxt = {rxd_i, rx_sh_r[9:1]};
  wire rx_mid_w = tick_w & (rx_ph_r == `DUA_OVS_LAST);
  wire rx_last_w = (rx_st_r == DUA_RX_BITS) & rx_mid_w &
                   (rx_cnt_r == rx_len_w - 4'd1);
  wire [7:0] rx_byte_w = nine_bit_i ? rx_sh_nxt[7:0] : rx_sh_nxt[8:1];

  // Start is confirmed at half a bit, then bits are taken every 16.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_r <= DUA_RX_IDLE;
      rx_ph_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_sh_r <= 10'h3ff;
    end else if (ce_i) begin
      unique case (rx_st_r)
        DUA_RX_IDLE: begin
          if (rx_en_i & ~rxd_i) begin
            rx_st_r <= DUA_RX_START;
            rx_ph_r <= 4'h0;
          end
        end
        DUA_RX_START: begin
          if (tick_w) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == `DUA_MID_BIT) begin
              rx_ph_r <= 4'h0;
              rx_cnt_r <= 4'h0;
              rx_st_r <= rxd_i ? DUA_RX_IDLE : DUA_RX_BITS;
            end
          end
        end
        DUA_RX_BITS: begin
          if (tick_w) rx_ph_r <= rx_ph_r + 4'h1;
          if (rx_mid_w) begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_last_w) rx_st_r <= DUA_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Ninth place holds the stop bit in eight-bit framing.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_data_r <= 8'h00;
      rx_ninth_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else if (ce_i) begin
      rx_done_r <= rx_last_w;
      if (rx_last_w) begin
        rx_data_r <= rx_byte_w;
        rx_ninth_r <= nine_bit_i ? rx_sh_nxt[8] : rx_sh_nxt[9];
      end
    end
  end

  // Software flow control: a received stop character halts sending.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) paused_r <= 1'b0;
    else if (ce_i) begin
      if (!flow_en_i) paused_r <= 1'b0;
      else if (rx_last_w & (rx_byte_w == `DUA_XOFF)) paused_r <= 1'b1;
      else if (rx_last_w & (rx_byte_w == `DUA_XON)) paused_r <= 1'b0;
    end
  end

  assign rx_done_o = rx_done_r;
  assign rx_data_o = rx_data_r;
  assign rx_ninth_o = rx_ninth_r;

endmodule : dua_chan

/* File: core/dua_consts.svh */
// Purpose: Shared constants of the dual serial port block.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes: Included by its bare name; definitions only.
`ifndef DUA_CONSTS_SVH
`define DUA_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DUA_OFF_P_TXB 8'h00
`define DUA_OFF_P_RXB 8'h04
`define DUA_OFF_P_CTL 8'h08
`define DUA_OFF_P_OPT 8'h0c
`define DUA_OFF_S_TXB 8'h10
`define DUA_OFF_S_RXB 8'h14
`define DUA_OFF_S_CTL 8'h18
`define DUA_OFF_S_OPT 8'h1c
`define DUA_OFF_RATE_SRC 8'h20
`define DUA_OFF_TMR_HI 8'h24
`define DUA_OFF_P_REL 8'h28
`define DUA_OFF_S_REL 8'h2c
`define DUA_OFF_PWR 8'h30
`define DUA_OFF_STAT 8'h34

// ****************************************************************
// Field positions
// ****************************************************************
`define DUA_CTL_MODE_HI 7
`define DUA_CTL_MODE_LO 6
`define DUA_CTL_RX_EN 4
`define DUA_CTL_TX_NINTH 3
`define DUA_CTL_RX_NINTH 2
`define DUA_CTL_TX_DONE 1
`define DUA_CTL_RX_DONE 0
`define DUA_OPT_PAR_AUTO 0
`define DUA_OPT_PAR_ODD 1
`define DUA_OPT_TWO_STOP 2
`define DUA_OPT_FLOW 3
`define DUA_SRC_SEL 7
`define DUA_PWR_DBL 7

// ****************************************************************
// Reset values
// ****************************************************************
`define DUA_RST_MODE 2'b01
`define DUA_RST_OPT 4'h0
`define DUA_RST_REL 10'h000
`define DUA_RST_TMR 8'h00

// ****************************************************************
// Timing counts in ticks of sixteen per bit, rate factors and flow characters
// ****************************************************************
`define DUA_OVS_LAST 4'hf
`define DUA_MID_BIT 4'h7
`define DUA_TMR_FACT 16'd24
`define DUA_INT_FACT 16'd4
`define DUA_SEC_FACT 16'd2
`define DUA_FIX_DIV 16'd4
`define DUA_RANGE_INT 11'h400
`define DUA_RANGE_TMR 9'h100
`define DUA_XON 8'h11
`define DUA_XOFF 8'h13

`endif

/* File: core/dua_pkg.sv */
// Purpose: Types shared by the dual serial port block.
// Assumes: Nothing beyond the header of constants.
// Notes: The receiver state type lives here.
package dua_pkg;

  // Receiver sequence: idle, start check, data sampling.
  typedef enum logic [1:0] {
    DUA_RX_IDLE,
    DUA_RX_START,
    DUA_RX_BITS
  } dua_rx_state_t;

endpackage : dua_pkg

/* File: core/dua_top.sv */
// What this block does
// - One input, one output line; LSB first.
// - Transmitter shifts out least significant bit first.
// - Writing transmit buffer launches that port's frame.
// - Separate receive buffer holds each completed character.
// - Both ports run full duplex, independently.
// - Source bit picks timer or internal generator.
// - Timer rate: clock over 384(256-reload), doubled when the doubling bit is set.
// - Generator rates: 64 or 32 times (1024-reload).
// - Each generator reload is a ten-bit value.
// - Primary mode 1: eight data bits, variable rate.
// - Primary mode 2: nine bits, clock/32 or /64.
// - Primary mode 3: nine bits, variable rate.
// - Secondary mode 0: nine bits, generator rate.
// - Secondary mode 1: eight bits, generator rate.
// - Up to 38400 bit/s at 1.2288 MHz.
// - Parity on/off, sense, stop count, flow control.
// - Hardware sets done flags; software alone clears.
// - Primary reception only while receive enable set.
// - Ninth bit sent from control, received into status.
//
// Purpose: Dual serial port with rate generators behind Wishbone.
// Assumes: Classic Wishbone, 32-bit data, 20 MHz processor clock.
// Notes: Rates follow the clock on clk_i; all outputs are registered.
`timescale 1ns/1ns
`include "dua_consts.svh"

module dua_top import dua_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic prim_rxd_i,
  output logic prim_txd_o,
  input wire logic sec_rxd_i,
  output logic sec_txd_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic prim_rx_s1_r;
  logic prim_rx_s2_r;
  logic sec_rx_s1_r;
  logic sec_rx_s2_r;

  // Reset to the idle-high level so no false start after reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prim_rx_s1_r <= 1'b1;
      prim_rx_s2_r <= 1'b1;
      sec_rx_s1_r <= 1'b1;
      sec_rx_s2_r <= 1'b1;
    end else if (ce_i) begin
      prim_rx_s1_r <= prim_rxd_i;
      prim_rx_s2_r <= prim_rx_s1_r;
      sec_rx_s1_r <= sec_rxd_i;
      sec_rx_s2_r <= sec_rx_s1_r;
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic ack_r;
  logic [31:0] dat_r;

  // A write takes effect on the edge where ack is seen high.
  wire acc_w = wb_cyc_i & wb_stb_i;
  wire wr_w = acc_w & wb_we_i & ack_r;
  wire wr0_w = wr_w & wb_sel_i[0];
  wire wr1_w = wr_w & wb_sel_i[1];
  wire [7:0] wadr_w = {wb_adr_i[7:2], 2'b00};
  wire [7:0] wd_w = wb_dat_i[7:0];

  wire hit_ptxb_w = (wadr_w == `DUA_OFF_P_TXB);
  wire hit_prxb_w = (wadr_w == `DUA_OFF_P_RXB);
  wire hit_pctl_w = (wadr_w == `DUA_OFF_P_CTL);
  wire hit_popt_w = (wadr_w == `DUA_OFF_P_OPT);
  wire hit_stxb_w = (wadr_w == `DUA_OFF_S_TXB);
  wire hit_srxb_w = (wadr_w == `DUA_OFF_S_RXB);
  wire hit_sctl_w = (wadr_w == `DUA_OFF_S_CTL);
  wire hit_sopt_w = (wadr_w == `DUA_OFF_S_OPT);
  wire hit_src_w = (wadr_w == `DUA_OFF_RATE_SRC);
  wire hit_tmr_w = (wadr_w == `DUA_OFF_TMR_HI);
  wire hit_prel_w = (wadr_w == `DUA_OFF_P_REL);
  wire hit_srel_w = (wadr_w == `DUA_OFF_S_REL);
  wire hit_pwr_w = (wadr_w == `DUA_OFF_PWR);
  wire hit_stat_w = (wadr_w == `DUA_OFF_STAT);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [1:0] prim_mode_r;
  logic prim_rx_en_r;
  logic prim_tx_ninth_r;
  logic [3:0] prim_opt_r;
  logic sec_mode_r;
  logic sec_rx_en_r;
  logic sec_tx_ninth_r;
  logic [3:0] sec_opt_r;
  logic rate_src_r;
  logic [7:0] tmr_hi_r;
  logic [9:0] prim_rel_r;
  logic [9:0] sec_rel_r;
  logic dbl_rate_r;

  // Plain software-owned bits; the reload high bits use byte lane 1.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prim_mode_r <= `DUA_RST_MODE;
      prim_rx_en_r <= 1'b0;
      prim_tx_ninth_r <= 1'b0;
      prim_opt_r <= `DUA_RST_OPT;
      sec_mode_r <= 1'b1;
      sec_rx_en_r <= 1'b0;
      sec_tx_ninth_r <= 1'b0;
      sec_opt_r <= `DUA_RST_OPT;
    end else if (ce_i) begin
      if (wr0_w & hit_pctl_w) begin
        prim_mode_r <= {wd_w[`DUA_CTL_MODE_HI],
                        wd_w[`DUA_CTL_MODE_LO]};
        prim_rx_en_r <= wd_w[`DUA_CTL_RX_EN];
        prim_tx_ninth_r <= wd_w[`DUA_CTL_TX_NINTH];
      end
      if (wr0_w & hit_popt_w) prim_opt_r <= wd_w[3:0];
      if (wr0_w & hit_sctl_w) begin
        sec_mode_r <= wd_w[`DUA_CTL_MODE_HI];
        sec_rx_en_r <= wd_w[`DUA_CTL_RX_EN];
        sec_tx_ninth_r <= wd_w[`DUA_CTL_TX_NINTH];
      end
      if (wr0_w & hit_sopt_w) sec_opt_r <= wd_w[3:0];
    end
  end

  // Rate registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rate_src_r <= 1'b0;
      tmr_hi_r <= `DUA_RST_TMR;
      prim_rel_r <= `DUA_RST_REL;
      sec_rel_r <= `DUA_RST_REL;
      dbl_rate_r <= 1'b0;
    end else if (ce_i) begin
      if (wr0_w & hit_src_w) rate_src_r <= wd_w[`DUA_SRC_SEL];
      if (wr0_w & hit_tmr_w) tmr_hi_r <= wd_w;
      if (wr0_w & hit_prel_w) prim_rel_r[7:0] <= wd_w;
      if (wr1_w & hit_prel_w) prim_rel_r[9:8] <= wb_dat_i[9:8];
      if (wr0_w & hit_srel_w) sec_rel_r[7:0] <= wd_w;
      if (wr1_w & hit_srel_w) sec_rel_r[9:8] <= wb_dat_i[9:8];
      if (wr0_w & hit_pwr_w) dbl_rate_r <= wd_w[`DUA_PWR_DBL];
    end
  end

  // ****************************************************************
  // Rate divisors, clock cycles per sixteenth of a bit
  // ****************************************************************
  // The sixteenfold oversampling divides out of 384, 64 and 32 exactly,
  // so every rate of the formulas is met with no rounding error.
  wire [10:0] prim_gap_w = `DUA_RANGE_INT - {1'b0, prim_rel_r};
  wire [10:0] sec_gap_w = `DUA_RANGE_INT - {1'b0, sec_rel_r};
  wire [8:0] tmr_gap_w = `DUA_RANGE_TMR - {1'b0, tmr_hi_r};
  wire [15:0] prim_int_w = {5'b00000, prim_gap_w} * `DUA_INT_FACT;
  wire [15:0] tmr_div_w = {7'b0000000, tmr_gap_w} * `DUA_TMR_FACT;
  wire [15:0] prim_var_w = rate_src_r ? prim_int_w : tmr_div_w;
  wire prim_fixed_w = (prim_mode_r == 2'b10);
  wire [15:0] prim_base_w = prim_fixed_w ? `DUA_FIX_DIV : prim_var_w;
  wire [15:0] prim_div_w = prim_base_w >> dbl_rate_r;
  // The secondary port has no timer path and no doubling.
  wire [15:0] sec_div_w = {5'b00000, sec_gap_w} * `DUA_SEC_FACT;

  // ****************************************************************
  // Port controls
  // ****************************************************************
  // Mode 00 of the primary port is unused: sending and reception stay off.
  wire prim_on_w = (prim_mode_r != 2'b00);
  wire prim_nine_w = prim_mode_r[1];
  wire sec_nine_w = ~sec_mode_r;
  wire prim_load_w = wr0_w & hit_ptxb_w & prim_on_w;
  wire sec_load_w = wr0_w & hit_stxb_w;
  wire prim_rx_on_w = prim_rx_en_r & prim_on_w;

  // ****************************************************************
  // Serial ports
  // ****************************************************************
  logic prim_busy_w;
  logic prim_tdone_w;
  logic prim_rdone_w;
  logic [7:0] prim_rdata_w;
  logic prim_rninth_w;
  logic sec_busy_w;
  logic sec_tdone_w;
  logic sec_rdone_w;
  logic [7:0] sec_rdata_w;
  logic sec_rninth_w;

  // Two independent instances, so both ports run full duplex at once.
  dua_chan u_prim (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .div_i(prim_div_w),
    .tx_load_i(prim_load_w),
    .tx_data_i(wd_w),
    .tx_ninth_i(prim_tx_ninth_r),
    .nine_bit_i(prim_nine_w),
    .par_auto_i(prim_opt_r[`DUA_OPT_PAR_AUTO]),
    .par_odd_i(prim_opt_r[`DUA_OPT_PAR_ODD]),
    .two_stop_i(prim_opt_r[`DUA_OPT_TWO_STOP]),
    .flow_en_i(prim_opt_r[`DUA_OPT_FLOW]),
    .rx_en_i(prim_rx_on_w),
    .rxd_i(prim_rx_s2_r),
    .txd_o(prim_txd_o),
    .tx_busy_o(prim_busy_w),
    .tx_done_o(prim_tdone_w),
    .rx_done_o(prim_rdone_w),
    .rx_data_o(prim_rdata_w),
    .rx_ninth_o(prim_rninth_w)
  );

  dua_chan u_sec (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .div_i(sec_div_w),
    .tx_load_i(sec_load_w),
    .tx_data_i(wd_w),
    .tx_ninth_i(sec_tx_ninth_r),
    .nine_bit_i(sec_nine_w),
    .par_auto_i(sec_opt_r[`DUA_OPT_PAR_AUTO]),
    .par_odd_i(sec_opt_r[`DUA_OPT_PAR_ODD]),
    .two_stop_i(sec_opt_r[`DUA_OPT_TWO_STOP]),
    .flow_en_i(sec_opt_r[`DUA_OPT_FLOW]),
    .rx_en_i(sec_rx_en_r),
    .rxd_i(sec_rx_s2_r),
    .txd_o(sec_txd_o),
    .tx_busy_o(sec_busy_w),
    .tx_done_o(sec_tdone_w),
    .rx_done_o(sec_rdone_w),
    .rx_data_o(sec_rdata_w),
    .rx_ninth_o(sec_rninth_w)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic prim_tdone_r;
  logic prim_rdone_r;
  logic prim_rninth_r;
  logic sec_tdone_r;
  logic sec_rdone_r;
  logic sec_rninth_r;

  // Writing 0 clears a flag, writing 1 leaves it; a set in the same
  // cycle wins, so no completion is ever lost to a racing clear.
  wire pclr_w = wr0_w & hit_pctl_w;
  wire sclr_w = wr0_w & hit_sctl_w;
  wire prim_tdone_nxt = prim_tdone_w |
         (prim_tdone_r & ~(pclr_w & ~wd_w[`DUA_CTL_TX_DONE]));
  wire prim_rdone_nxt = prim_rdone_w |
         (prim_rdone_r & ~(pclr_w & ~wd_w[`DUA_CTL_RX_DONE]));
  wire prim_rninth_nxt = prim_rdone_w ? prim_rninth_w :
         (prim_rninth_r & ~(pclr_w & ~wd_w[`DUA_CTL_RX_NINTH]));
  wire sec_tdone_nxt = sec_tdone_w |
         (sec_tdone_r & ~(sclr_w & ~wd_w[`DUA_CTL_TX_DONE]));
  wire sec_rdone_nxt = sec_rdone_w |
         (sec_rdone_r & ~(sclr_w & ~wd_w[`DUA_CTL_RX_DONE]));
  wire sec_rninth_nxt = sec_rdone_w ? sec_rninth_w :
         (sec_rninth_r & ~(sclr_w & ~wd_w[`DUA_CTL_RX_NINTH]));

  // Flag registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prim_tdone_r <= 1'b0;
      prim_rdone_r <= 1'b0;
      prim_rninth_r <= 1'b0;
      sec_tdone_r <= 1'b0;
      sec_rdone_r <= 1'b0;
      sec_rninth_r <= 1'b0;
    end else if (ce_i) begin
      prim_tdone_r <= prim_tdone_nxt;
      prim_rdone_r <= prim_rdone_nxt;
      prim_rninth_r <= prim_rninth_nxt;
      sec_tdone_r <= sec_tdone_nxt;
      sec_rdone_r <= sec_rdone_nxt;
      sec_rninth_r <= sec_rninth_nxt;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [7:0] pctl_w = {prim_mode_r, 1'b0, prim_rx_en_r, prim_tx_ninth_r,
                       prim_rninth_r, prim_tdone_r, prim_rdone_r};
  wire [7:0] sctl_w = {sec_mode_r, 2'b00, sec_rx_en_r, sec_tx_ninth_r,
                       sec_rninth_r, sec_tdone_r, sec_rdone_r};
  // Transmit buffers are write-only and read as zero, like any hole.
  wire [31:0] rd_w =
    hit_prxb_w ? {24'h000000, prim_rdata_w} :
    hit_pctl_w ? {24'h000000, pctl_w} :
    hit_popt_w ? {28'h0000000, prim_opt_r} :
    hit_srxb_w ? {24'h000000, sec_rdata_w} :
    hit_sctl_w ? {24'h000000, sctl_w} :
    hit_sopt_w ? {28'h0000000, sec_opt_r} :
    hit_src_w ? {24'h000000, rate_src_r, 7'h00} :
    hit_tmr_w ? {24'h000000, tmr_hi_r} :
    hit_prel_w ? {22'h000000, prim_rel_r} :
    hit_srel_w ? {22'h000000, sec_rel_r} :
    hit_pwr_w ? {24'h000000, dbl_rate_r, 7'h00} :
    hit_stat_w ? {30'h00000000, sec_busy_w, prim_busy_w} :
    32'h00000000;

  // Ack one cycle after the request, dropped the cycle after it rose.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r <= acc_w & ~ack_r;
      if (acc_w & ~ack_r) dat_r <= rd_w;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : dua_top

/* File: testbench/dua_peer.sv */
// Purpose: Far-side serial device for one port.
// Assumes: Bit time given in clocks by the caller.
// Notes: Line idles high between frames.
`timescale 1ns/1ns
module dua_peer (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // Start low, data LSB first, ending on the stop level.
  task automatic send(input logic [9:0] d, input int n, input int bt);
    @(posedge clk_i);
    for (int i = -1; i <= n; i++) begin
      rxd_o <= (i < 0) ? 1'b0 : d[i];
      repeat (bt) @(posedge clk_i);
    end
  endtask : send
  // Sample at bit centres; a bad start bit returns all ones.
  task automatic grab(output logic [9:0] d, input int n, input int bt);
    logic ok;
    d = '0;
    @(negedge txd_i);
    repeat (bt / 2) @(posedge clk_i);
    ok = (txd_i === 1'b0);
    for (int i = 0; i <= n; i++) begin
      repeat (bt) @(posedge clk_i);
      d[i] = txd_i;
    end
    if (!ok) d = '1;
  endtask : grab
endmodule : dua_peer

/* File: testbench/dua_top_asserts.sv */
// Purpose: Port checks for the dual serial port.
// Assumes: Every serial bit lasts 32 clocks or more.
// Notes: Bound to every instance of the top.
`timescale 1ns/1ns
module dua_top_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic prim_txd_o,
  input wire logic sec_txd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // A request the slave must take.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_hole_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 8'h3c)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_ptx_low: assert property ($fell(prim_txd_o) |-> !prim_txd_o [*8])
    else $error("primary low bit too short");
  a_ptx_high: assert property ($rose(prim_txd_o) |-> prim_txd_o [*8])
    else $error("primary high bit too short");
  a_stx_low: assert property ($fell(sec_txd_o) |-> !sec_txd_o [*8])
    else $error("secondary low bit too short");
  // A low enable must freeze both serial outputs and the ack.
  a_ce_hold: assert property (!ce_i |=> $stable(prim_txd_o)
    && $stable(sec_txd_o) && $stable(wb_ack_o)) else $error("moved frozen");
endmodule : dua_top_asserts
bind dua_top dua_top_asserts u_chk (.clk_i, .rst_b_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .prim_txd_o,
  .sec_txd_o);

/* File: testbench/dua_top_test.sv */
// Purpose: Self-checking bench for the dual serial port.
// Assumes: Reload 1023 gives 64 primary, 32 secondary clocks a bit.
// Notes: A peer stands on each serial port.
`timescale 1ns/1ns
module dua_top_test;
  logic clk_i = 0, rst_b_i = 0, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, q;
  logic [9:0] got;
  wire logic [31:0] rdat;
  wire logic ack, ptx, stx, prx, srx;
  int n_errors = 0, samples_checked = 0;
  dua_top dut (.clk_i, .rst_b_i, .ce_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .prim_rxd_i(prx), .prim_txd_o(ptx),
    .sec_rxd_i(srx), .sec_txd_o(stx));
  dua_peer p0 (.clk_i, .txd_i(ptx), .rxd_o(prx));
  dua_peer p1 (.clk_i, .txd_i(stx), .rxd_o(srx));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One classic cycle; read data is taken at the ack edge.
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i);
    while (!ack);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask : bus
  task automatic tx(input logic p, input logic [7:0] d, input int n, bt,
    input logic [9:0] e);
    fork
      if (p) p1.grab(got, n, bt); else p0.grab(got, n, bt);
      bus(1, {3'h0, p, 4'h0}, d);
    join
    chk("frame", got, e);
  endtask : tx
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    #3000000;
    n_errors++;
    close_out();
  end
  // ********
  // Sequence
  // ********
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1;
    bus(0, 8'h08, 0); chk("pctl", q[7:0], 8'h40);
    bus(0, 8'h18, 0); chk("sctl", q[7:0], 8'h80);
    bus(0, 8'h3c, 0); chk("hole", q, 0);
    ce_i <= 0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1;
    bus(1, 8'h20, 8'h80);
    bus(1, 8'h28, 32'h3ff);
    bus(1, 8'h2c, 32'h3ff);
    bus(1, 8'h08, 8'h50);
    bus(1, 8'h18, 8'h90);
    fork
      tx(0, 8'ha5, 8, 64, 10'h1a5);
      p0.send(10'h13c, 8, 64);
      p1.send(10'h1c3, 8, 32);
    join
    bus(0, 8'h04, 0); chk("prx", q[7:0], 8'h3c);
    bus(0, 8'h14, 0); chk("srx", q[7:0], 8'hc3);
    bus(0, 8'h08, 0); chk("flags", q[7:0], 8'h57);
    bus(1, 8'h08, 8'h50);
    bus(0, 8'h08, 0); chk("clear", q[7:0], 8'h50);
    tx(1, 8'h5a, 8, 32, 10'h15a);
    bus(1, 8'h18, 8'h18);
    tx(1, 8'h0f, 9, 32, 10'h30f);
    // Odd auto parity overrides the ninth bit; two stops keep busy longer.
    bus(1, 8'h1c, 8'h07);
    tx(1, 8'h07, 9, 32, 10'h207);
    repeat (24) @(posedge clk_i);
    bus(0, 8'h34, 0); chk("stop2", q, 2);
    // A received stop character holds the next frame until resumed.
    bus(1, 8'h1c, 8'h08);
    p1.send(10'h313, 9, 32);
    bus(1, 8'h10, 8'h44);
    repeat (400) @(posedge clk_i);
    bus(0, 8'h34, 0); chk("xoff", q, 2);
    fork
      p1.send(10'h311, 9, 32);
      p1.grab(got, 9, 32);
    join
    chk("xon", got, 10'h344);
    bus(1, 8'h08, 8'hd0);
    tx(0, 8'hf0, 9, 64, 10'h2f0);
    p0.send(10'h381, 9, 64);
    bus(0, 8'h04, 0); chk("p9rx", q[7:0], 8'h81);
    bus(0, 8'h08, 0); chk("p9fl", q[7:0], 8'hd7);
    bus(1, 8'h30, 8'h80);
    bus(1, 8'h08, 8'h90);
    tx(0, 8'h33, 9, 32, 10'h233);
    bus(1, 8'h30, 0);
    bus(1, 8'h20, 0);
    bus(1, 8'h24, 8'hff);
    bus(1, 8'h08, 8'h40);
    tx(0, 8'h96, 8, 384, 10'h196);
    p0.send(10'h1aa, 8, 384);
    bus(0, 8'h08, 0); chk("rxoff", q[7:0], 8'h42);
    bus(0, 8'h04, 0); chk("rxkeep", q[7:0], 8'h81);
    // Mode 00 is unused, so a transmit write must not start anything.
    bus(1, 8'h08, 8'h00);
    bus(1, 8'h00, 8'h55);
    bus(0, 8'h34, 0); chk("off", q, 0);
    close_out();
  end
endmodule : dua_top_test
